// ==== core/osf_pkg.sv ====
/*
 sector framer constants: field lengths in 12-channel-bit slots, fixed channel patterns,
 address crc settings and the framer state encoding.
 assumes every field length counts whole slots of one byte (12 channel bits) each.
*/
package osf_pkg;
	localparam int          SLOT_CBITS    = 12;
	localparam int          SM_LEN        = 8;
	localparam int          HEADER_LOCK_PREAMBLE_ONE_LEN      = 26;
	localparam int          AM_LEN        = 1;
	localparam int          ADDR_LEN      = 5;
	localparam int          HEADER_LOCK_PREAMBLE_TWO_LEN      = 16;
	localparam int          PA_LEN        = 1;
	localparam int          GAP_LEN       = 20;
	localparam int          GAP_CBITS     = 240;
	localparam int          RECORDING_LOCK_PREAMBLE_LEN      = 27;
	localparam int          SYNC_LEN      = 4;
	localparam int          SYNC_CBITS    = 48;
	localparam int          DATA_LEN      = 2458;
	localparam int          FILL_LEN      = 8;
	localparam int          FIFO_LEN      = DATA_LEN - FILL_LEN;
	localparam int          BUF_CTRL_LEN  = 121;
	localparam int          BUF_STD_LEN   = 58;
	localparam int          BUF_CTRL_CB   = 1452;
	localparam int          BUF_STD_CB    = 696;
	localparam int          HDR_LEN       = 63;
	localparam int          SECTOR_CTRL   = 2694;
	localparam int          SECTOR_STD    = 2631;
	localparam int          MAX_SECTOR    = 16;
	localparam int          PLACE_TOL_CB  = 6;
	localparam int          SM_CBITS      = 96;
	localparam logic [5:0]  SM_LEADIN_ODD = 6'h05;
	localparam logic [5:0]  SM_LEADIN_EVN = 6'h01;
	localparam logic [11:0] VFO_SLOT      = 12'h249;
	localparam logic [2:0]  HEAD_BITS     = 3'h2;
	localparam logic [7:0]  HEADER_LOCK_PREAMBLE_TWO_TAIL     = 8'h49;
	localparam logic        HEADER_LOCK_PREAMBLE_TWO_Q        = ^{HEAD_BITS, HEADER_LOCK_PREAMBLE_TWO_TAIL};
	localparam logic [7:0]  PA_TAIL       = 8'h48;
	localparam logic        PA_Q          = ^{HEAD_BITS, PA_TAIL};
	localparam logic [9:0]  AM_HEAD       = 10'h002;
	localparam logic [11:0] GAP_CTRL_SLOT = 12'haaa;
	localparam logic [11:0] GAP_STD_SLOT  = 12'h000;
	localparam logic [11:0] BUF_SLOT      = 12'h000;
	localparam logic [7:0]  FILL_BYTE     = 8'hff;
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY      = 16'h1021;
	localparam int          BAND_CTRL     = 17;

	typedef enum logic [1:0] {
		ZONE_LEADIN  = 2'h0,
		ZONE_DATA    = 2'h1,
		ZONE_CTRL    = 2'h2,
		ZONE_LEADOUT = 2'h3
	} osf_zone_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_SMARK = 4'h1,
		ST_HEADER_LOCK_PREAMBLE_ONE  = 4'h3,
		ST_AM1   = 4'h2,
		ST_ADDR1 = 4'h6,
		ST_HEADER_LOCK_PREAMBLE_TWO  = 4'h7,
		ST_AM2   = 4'h5,
		ST_ADDR2 = 4'h4,
		ST_PA1   = 4'hc,
		ST_GAP   = 4'hd,
		ST_RECORDING_LOCK_PREAMBLE  = 4'hf,
		ST_SYNC  = 4'he,
		ST_DATA  = 4'ha,
		ST_FILL  = 4'hb,
		ST_PA2   = 4'h9,
		ST_BUF   = 4'h8
	} osf_state_t;
endpackage : osf_pkg

// ==== core/osf_fifo.sv ====
/*
 show-ahead fifo between the controller data path and the framer.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module osf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	assign o_ready = (cnt_r != (AW+1)'(DEPTH));
	assign o_valid = (cnt_r != '0);
	assign o_data  = mem_r[rp_r];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb begin
		wp_nxt  = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
		rp_nxt  = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push) begin
			mem_r[wp_r] <= i_data;
		end
	end
endmodule : osf_fifo

// ==== core/osf_addr_crc.sv ====
/*
 combinational 16-bit crc over the three leading address bytes, msb first.
 assumes the caller presents the bytes in field order.
*/
`timescale 1ns/1ps
module osf_addr_crc
	import osf_pkg::*;
(
	input  wire logic [23:0] i_bytes,
	output logic      [15:0] o_crc
);
	logic [15:0] c;
	logic        fb;

	always_comb begin
		c  = CRC_INIT;
		fb = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			fb = c[15] ^ i_bytes[i];
			c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		o_crc = c;
	end
endmodule : osf_addr_crc

// ==== core/osf_framer.sv ====
/*
 sector framer: emits one sector as a stream of 12-channel-bit slots, either raw
 channel patterns or bytes flagged for the external run-length encoder.
 assumes the channel takes a slot when valid and ready meet, and that the controller
 supplies the data field bytes (user, crc, ecc and resync) in recording order.
*/
// Summary of operation
// - header 63, gap 20, then recording field
// - sector totals 2694 control, 2631 elsewhere
// - header fields in fixed order and lengths
// - preamble 27, sync 4, data, closing, buffer
// - start pattern ends with band-parity lead-in
// - lead-in, control, lead-out zones pick variant
// - second preamble starts 010, seeded input 10
// - fourth preamble bit ends on trailing edge
// - recording preamble within six bits of ideal
// - align mark 000000001 0x0, x from next bits
// - address: track high, low, copy, sector
// - address bytes four, five hold crc
// - address encoding seeded from mark's last bits
// - closing pattern 010, fourth bit ends mark
// - gap 240 bits, control zone 2T fill
// - sync 48 bits, x from data start
// - data encoding seeded from sync's last bits
// - reed-solomon bytes arrive in data stream
// - buffer 1452 or 696 bits, no data
// - address and data bytes go to encoder
// - track carried as two's complement
// - sector numbers run zero to sixteen
// - header channel bits twice as long outside control zone
`timescale 1ns/1ps
module osf_framer
	import osf_pkg::*;
#(
	parameter logic [89:0] SM_LONG    = 90'h3ff_ffc0_0fff_f000_3fff_fc00,
	parameter logic [47:0] SYNC_WORD  = 48'h924_924_924_900,
	parameter int          SYNC_X_BIT = 2,
	parameter int          FIFO_DEPTH = 8
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_START,
	input  wire logic [1:0]  I_ZONE,
	input  wire logic [4:0]  I_BAND,
	input  wire logic [15:0] I_TRACK,
	input  wire logic [6:0]  I_SECTOR,
	input  wire logic [7:0]  I_DATA,
	input  wire logic        I_DATA_VALID,
	output logic             O_DATA_READY,
	output logic             O_SLOT_VALID,
	input  wire logic        I_SLOT_READY,
	output logic             O_SLOT_RAW,
	output logic      [11:0] O_SLOT_DATA,
	output logic      [3:0]  O_FIELD,
	output logic             O_HDR_RATE,
	output logic             O_SEED_LOAD,
	output logic      [1:0]  O_PREV_BITS,
	output logic             O_BUSY
);
	osf_state_t  st_r, st_nxt;
	logic [11:0] cnt_r, cnt_nxt, idx_r, idx_nxt, tot_r, tot_nxt;
	logic        ov_r, ov_nxt, raw_r, raw_nxt, hr_r, hr_nxt, seed_r, seed_nxt;
	logic [11:0] dat_r, dat_nxt;
	logic [3:0]  fld_r, fld_nxt;
	logic [1:0]  prev_r, prev_nxt;
	logic [15:0] trk_r, trk_nxt;
	logic [6:0]  sec_r, sec_nxt;
	logic        ctl_r, ctl_nxt, odd_r, odd_nxt;
	logic [7:0]  f_data;
	logic        f_valid, pop, load, stall;
	logic [15:0] crc;
	logic [95:0] sm_full, sm_sh;
	logic [47:0] sync_full, sync_sh;
	logic [11:0] slot;
	logic        is_raw, seed;

	function automatic logic [11:0] field_len(osf_state_t s, logic ctl);
		unique case (s)
			ST_SMARK: field_len = 12'(SM_LEN);
			ST_HEADER_LOCK_PREAMBLE_ONE:  field_len = 12'(HEADER_LOCK_PREAMBLE_ONE_LEN);
			ST_AM1,
			ST_AM2:   field_len = 12'(AM_LEN);
			ST_ADDR1,
			ST_ADDR2: field_len = 12'(ADDR_LEN);
			ST_HEADER_LOCK_PREAMBLE_TWO:  field_len = 12'(HEADER_LOCK_PREAMBLE_TWO_LEN);
			ST_PA1,
			ST_PA2:   field_len = 12'(PA_LEN);
			ST_GAP:   field_len = 12'(GAP_LEN);
			ST_RECORDING_LOCK_PREAMBLE:  field_len = 12'(RECORDING_LOCK_PREAMBLE_LEN);
			ST_SYNC:  field_len = 12'(SYNC_LEN);
			ST_DATA:  field_len = 12'(FIFO_LEN);
			ST_FILL:  field_len = 12'(FILL_LEN);
			ST_BUF:   field_len = ctl ? 12'(BUF_CTRL_LEN) : 12'(BUF_STD_LEN);
			ST_IDLE:  field_len = 12'h001;
		endcase
	endfunction : field_len

	function automatic osf_state_t field_next(osf_state_t s);
		unique case (s)
			ST_IDLE:  field_next = ST_SMARK;
			ST_SMARK: field_next = ST_HEADER_LOCK_PREAMBLE_ONE;
			ST_HEADER_LOCK_PREAMBLE_ONE:  field_next = ST_AM1;
			ST_AM1:   field_next = ST_ADDR1;
			ST_ADDR1: field_next = ST_HEADER_LOCK_PREAMBLE_TWO;
			ST_HEADER_LOCK_PREAMBLE_TWO:  field_next = ST_AM2;
			ST_AM2:   field_next = ST_ADDR2;
			ST_ADDR2: field_next = ST_PA1;
			ST_PA1:   field_next = ST_GAP;
			ST_GAP:   field_next = ST_RECORDING_LOCK_PREAMBLE;
			ST_RECORDING_LOCK_PREAMBLE:  field_next = ST_SYNC;
			ST_SYNC:  field_next = ST_DATA;
			ST_DATA:  field_next = ST_FILL;
			ST_FILL:  field_next = ST_PA2;
			ST_PA2:   field_next = ST_BUF;
			ST_BUF:   field_next = ST_IDLE;
		endcase
	endfunction : field_next

	osf_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (I_CORE_CLK),
		.i_rst   (I_RST),
		.i_data  (I_DATA),
		.i_valid (I_DATA_VALID),
		.o_ready (O_DATA_READY),
		.o_data  (f_data),
		.o_valid (f_valid),
		.i_ready (pop)
	);

	osf_addr_crc u_crc (
		.i_bytes ({trk_r, st_r == ST_ADDR2, sec_r}),
		.o_crc   (crc)
	);

	assign sm_full   = {SM_LONG, odd_r ? SM_LEADIN_ODD : SM_LEADIN_EVN};
	assign sm_sh     = sm_full << (7'(cnt_r[2:0]) * 7'd12);
	assign sync_full = SYNC_WORD | (48'(f_data[7:6] == 2'h0) << SYNC_X_BIT);
	assign sync_sh   = sync_full << (6'(cnt_r[1:0]) * 6'd12);
	assign stall     = (st_r == ST_SYNC || st_r == ST_DATA) && !f_valid;
	assign load      = (st_r != ST_IDLE) && (!ov_r || I_SLOT_READY) && !stall;
	assign pop       = load && (st_r == ST_DATA);

	// slot content for the current field position
	always_comb begin
		slot   = BUF_SLOT;
		is_raw = 1'b1;
		seed   = 1'b0;
		unique case (st_r)
			ST_SMARK: slot = sm_sh[95:84];
			ST_HEADER_LOCK_PREAMBLE_ONE,
			ST_RECORDING_LOCK_PREAMBLE:  slot = VFO_SLOT;
			ST_AM1,
			ST_AM2:   slot = {AM_HEAD, trk_r[15:14] == 2'h0, 1'b0};
			ST_ADDR1,
			ST_ADDR2: begin
				is_raw = 1'b0;
				unique case (cnt_r[2:0])
					3'h0:    slot = {4'h0, trk_r[15:8]};
					3'h1:    slot = {4'h0, trk_r[7:0]};
					3'h2:    slot = {4'h0, st_r == ST_ADDR2, sec_r};
					3'h3:    slot = {4'h0, crc[15:8]};
					default: slot = {4'h0, crc[7:0]};
				endcase
			end
			ST_HEADER_LOCK_PREAMBLE_TWO: begin
				seed = (cnt_r == 12'h000);
				slot = seed ? {HEAD_BITS, HEADER_LOCK_PREAMBLE_TWO_Q, HEADER_LOCK_PREAMBLE_TWO_TAIL} : VFO_SLOT;
			end
			ST_PA1,
			ST_PA2: begin
				seed = 1'b1;
				slot = {HEAD_BITS, PA_Q, PA_TAIL};
			end
			ST_GAP:   slot = ctl_r ? GAP_CTRL_SLOT : GAP_STD_SLOT;
			ST_SYNC:  slot = sync_sh[47:36];
			ST_DATA: begin
				is_raw = 1'b0;
				slot   = {4'h0, f_data};
			end
			ST_FILL: begin
				is_raw = 1'b0;
				slot   = {4'h0, FILL_BYTE};
			end
			ST_BUF:   slot = BUF_SLOT;
			ST_IDLE:  slot = BUF_SLOT;
		endcase
	end

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		idx_nxt  = idx_r;
		tot_nxt  = tot_r;
		ov_nxt   = ov_r && !I_SLOT_READY;
		raw_nxt  = raw_r;
		dat_nxt  = dat_r;
		fld_nxt  = fld_r;
		hr_nxt   = hr_r;
		seed_nxt = seed_r;
		prev_nxt = prev_r;
		trk_nxt  = trk_r;
		sec_nxt  = sec_r;
		ctl_nxt  = ctl_r;
		odd_nxt  = odd_r;
		if (st_r == ST_IDLE) begin
			if (I_START && !ov_r && I_SECTOR <= 7'(MAX_SECTOR)) begin
				st_nxt  = ST_SMARK;
				cnt_nxt = '0;
				tot_nxt = '0;
				trk_nxt = I_TRACK;
				sec_nxt = I_SECTOR;
				ctl_nxt = (I_ZONE == ZONE_CTRL);
				unique case (I_ZONE)
					ZONE_LEADIN:  odd_nxt = 1'b0;
					ZONE_CTRL:    odd_nxt = BAND_CTRL[0];
					ZONE_LEADOUT: odd_nxt = 1'b0;
					ZONE_DATA:    odd_nxt = I_BAND[0];
				endcase
			end
		end else if (load) begin
			ov_nxt   = 1'b1;
			raw_nxt  = is_raw;
			dat_nxt  = slot;
			fld_nxt  = st_r;
			idx_nxt  = cnt_r;
			seed_nxt = seed;
			tot_nxt  = tot_r + 12'h001;
			hr_nxt   = (tot_r < 12'(HDR_LEN)) && !ctl_r;
			if (is_raw) begin
				prev_nxt = slot[1:0];
			end
			if (cnt_r == field_len(st_r, ctl_r) - 12'h001) begin
				cnt_nxt = '0;
				st_nxt  = field_next(st_r);
			end else begin
				cnt_nxt = cnt_r + 12'h001;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			st_r   <= ST_IDLE;
			cnt_r  <= '0;
			idx_r  <= '0;
			tot_r  <= '0;
			ov_r   <= 1'b0;
			raw_r  <= 1'b1;
			dat_r  <= '0;
			fld_r  <= ST_IDLE;
			hr_r   <= 1'b0;
			seed_r <= 1'b0;
			prev_r <= '0;
			trk_r  <= '0;
			sec_r  <= '0;
			ctl_r  <= 1'b0;
			odd_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			idx_r  <= idx_nxt;
			tot_r  <= tot_nxt;
			ov_r   <= ov_nxt;
			raw_r  <= raw_nxt;
			dat_r  <= dat_nxt;
			fld_r  <= fld_nxt;
			hr_r   <= hr_nxt;
			seed_r <= seed_nxt;
			prev_r <= prev_nxt;
			trk_r  <= trk_nxt;
			sec_r  <= sec_nxt;
			ctl_r  <= ctl_nxt;
			odd_r  <= odd_nxt;
		end
	end

	assign O_SLOT_VALID = ov_r;
	assign O_SLOT_RAW   = raw_r;
	assign O_SLOT_DATA  = dat_r;
	assign O_FIELD      = fld_r;
	assign O_HDR_RATE   = hr_r;
	assign O_SEED_LOAD  = seed_r;
	assign O_PREV_BITS  = prev_r;
	assign O_BUSY       = (st_r != ST_IDLE) || ov_r;

	sector_len_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(st_r == ST_BUF && st_nxt == ST_IDLE)
		|=> (tot_r == (ctl_r ? 12'(SECTOR_CTRL) : 12'(SECTOR_STD))))
		else $error("sector slot count wrong");
	header_gap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(load && st_r == ST_RECORDING_LOCK_PREAMBLE && cnt_r == 12'h000)
		|-> (tot_r == 12'(HDR_LEN + GAP_LEN)) && (GAP_LEN * SLOT_CBITS == GAP_CBITS))
		else $error("header plus gap length wrong");
	preamble_place_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(load && st_r == ST_RECORDING_LOCK_PREAMBLE && cnt_r == 12'h000)
		|-> (12'(SLOT_CBITS) * tot_r - 12'(SLOT_CBITS * (HDR_LEN + GAP_LEN))
			<= 12'(PLACE_TOL_CB)))
		else $error("recording preamble misplaced");
	align_mark_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(ov_r && (fld_r == ST_AM1 || fld_r == ST_AM2))
		|-> (dat_r[11:2] == AM_HEAD) && !dat_r[0] && (dat_r[1] == (trk_r[15:14] == 2'h0)))
		else $error("align mark pattern wrong");
	copy_index_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(ov_r && fld_r == ST_ADDR2 && idx_r == 12'h002) |-> dat_r[7] && !raw_r)
		else $error("second copy index bit clear");
	closing_edge_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(ov_r && (fld_r == ST_PA1 || fld_r == ST_PA2))
		|-> (dat_r[11:9] == HEAD_BITS) && !(^dat_r) && seed_r)
		else $error("closing pattern not ending on mark edge");
	preamble_two_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(load && st_r == ST_HEADER_LOCK_PREAMBLE_TWO && cnt_r == 12'h000)
		|=> seed_r && (dat_r[11:9] == HEAD_BITS) && (dat_r[8] == HEADER_LOCK_PREAMBLE_TWO_Q) && !(^dat_r))
		else $error("second preamble head wrong");
	leadin_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(load && st_r == ST_SMARK && cnt_r == 12'(SM_LEN - 1))
		|=> (dat_r[5:0] == (odd_r ? SM_LEADIN_ODD : SM_LEADIN_EVN)))
		else $error("start pattern lead-in wrong");
	fill_ff_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(ov_r && fld_r == ST_FILL) |-> (dat_r[7:0] == FILL_BYTE) && !raw_r)
		else $error("fill byte not FF");
	header_rate_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(load && st_r == ST_GAP) |=> !hr_r)
		else $error("gap slot flagged at header rate");
	buffer_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(ov_r && fld_r == ST_BUF) |-> raw_r && (dat_r == BUF_SLOT)
			&& (BUF_CTRL_LEN * SLOT_CBITS == BUF_CTRL_CB) && (BUF_STD_LEN * SLOT_CBITS == BUF_STD_CB))
		else $error("buffer slot carries data");
	slot_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(ov_r && !I_SLOT_READY) |=> ov_r && $stable(dat_r) && $stable(fld_r) && $stable(raw_r))
		else $error("pending slot changed before taken");
	sync_x_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(load && st_r == ST_SYNC && cnt_r == 12'(SYNC_LEN - 1))
		|=> (dat_r[SYNC_X_BIT] == ($past(f_data[7:6]) == 2'h0)))
		else $error("sync variable bit wrong");
	start_refuse_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(st_r == ST_IDLE && I_START && I_SECTOR > 7'(MAX_SECTOR)) |=> (st_r == ST_IDLE))
		else $error("out-of-range sector started");
endmodule : osf_framer

// ==== verif/osf_chan_model.sv ====
/*
 channel-side slot sink: takes slots with optional random stalls and
 counts byte-align marks found in the raw channel bit stream.
 assumes slots are handed over where valid and ready meet at a rising edge.
*/
`timescale 1ns/1ps
module osf_chan_model (
	input  wire logic        i_clk,
	input  wire logic        i_stall,
	input  wire logic        i_valid,
	input  wire logic        i_raw,
	input  wire logic [11:0] i_data,
	output logic             o_ready,
	output int               o_marks
);
	logic last_r;

	initial begin
		o_ready = 1'b1;
		o_marks = 0;
		last_r  = 1'b0;
	end

	always @(posedge i_clk) begin
		if (i_valid && o_ready) begin
			// a one, eight zeros, then a one aligns bytes
			if (i_raw && last_r && i_data[11:4] == 8'h00 && i_data[3])
				o_marks <= o_marks + 1;
			last_r <= i_raw & i_data[0];
		end
		#1 o_ready = !i_stall || ($urandom % 4 != 0);
	end
endmodule : osf_chan_model

// ==== verif/tb.sv ====
/*
 sector framer testbench: queue model of every slot, data feeder, channel sink.
 assumes the design package and the channel model are compiled before it.
*/
`timescale 1ns/1ps
module tb
	import osf_pkg::*;
;
	localparam logic [89:0] SM_L   = 90'h3ff_ffc0_0fff_f000_3fff_fc00;
	localparam logic [47:0] SYNC_W = 48'h924_924_924_900;
	localparam int          SX     = 2;
	localparam int          FD     = 8;

	logic        clk, rst, start, hdr, seed, busy, stall;
	logic        dvalid, dready, svalid, sready, sraw;
	logic [1:0]  zone, prev;
	logic [4:0]  band;
	logic [15:0] track;
	logic [6:0]  sector;
	logic [7:0]  din;
	logic [11:0] sdata;
	logic [3:0]  field;
	int          marks, fail_count, num_checks;
	logic [21:0] exp_q[$];
	logic [7:0]  bytes[FIFO_LEN];

	osf_framer #(.SM_LONG(SM_L), .SYNC_WORD(SYNC_W), .SYNC_X_BIT(SX), .FIFO_DEPTH(FD)) uut (
		.I_CORE_CLK(clk), .I_RST(rst), .I_START(start), .I_ZONE(zone), .I_BAND(band),
		.I_TRACK(track), .I_SECTOR(sector), .I_DATA(din), .I_DATA_VALID(dvalid),
		.O_DATA_READY(dready), .O_SLOT_VALID(svalid), .I_SLOT_READY(sready),
		.O_SLOT_RAW(sraw), .O_SLOT_DATA(sdata), .O_FIELD(field), .O_HDR_RATE(hdr),
		.O_SEED_LOAD(seed), .O_PREV_BITS(prev), .O_BUSY(busy));

	osf_chan_model chan (.i_clk(clk), .i_stall(stall), .i_valid(svalid), .i_raw(sraw),
		.i_data(sdata), .o_ready(sready), .o_marks(marks));

	always #12.5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	function automatic logic [15:0] crc16(input logic [23:0] d);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : crc16

	task automatic build(input logic [1:0] z, input logic [4:0] b, input logic [15:0] t,
			input logic [6:0] s);
		logic [95:0] sm;
		logic [47:0] sw;
		logic [39:0] id;
		logic [23:0] a;
		logic [11:0] d;
		logic [1:0]  pv;
		logic        r, odd;
		osf_state_t  seq[15];
		int          len[15];
		seq = '{ST_SMARK, ST_HEADER_LOCK_PREAMBLE_ONE, ST_AM1, ST_ADDR1, ST_HEADER_LOCK_PREAMBLE_TWO, ST_AM2, ST_ADDR2, ST_PA1,
			ST_GAP, ST_RECORDING_LOCK_PREAMBLE, ST_SYNC, ST_DATA, ST_FILL, ST_PA2, ST_BUF};
		len = '{SM_LEN, HEADER_LOCK_PREAMBLE_ONE_LEN, AM_LEN, ADDR_LEN, HEADER_LOCK_PREAMBLE_TWO_LEN, AM_LEN, ADDR_LEN, PA_LEN,
			GAP_LEN, RECORDING_LOCK_PREAMBLE_LEN, SYNC_LEN, FIFO_LEN, FILL_LEN, PA_LEN,
			(z == ZONE_CTRL) ? BUF_CTRL_LEN : BUF_STD_LEN};
		odd = (z == ZONE_CTRL) || (z == ZONE_DATA && b[0]);
		sm = {SM_L, odd ? SM_LEADIN_ODD : SM_LEADIN_EVN};
		sw = SYNC_W | (48'(bytes[0][7:6] == 2'b00) << SX);
		pv = 2'b00;
		exp_q.delete();
		for (int k = 0; k < 15; k++) begin
			for (int i = 0; i < len[k]; i++) begin
				r = 1'b1;
				case (seq[k])
					ST_SMARK: d = sm[95-12*i -: 12];
					ST_HEADER_LOCK_PREAMBLE_ONE, ST_RECORDING_LOCK_PREAMBLE: d = VFO_SLOT;
					ST_HEADER_LOCK_PREAMBLE_TWO: d = (i == 0) ? {HEAD_BITS, HEADER_LOCK_PREAMBLE_TWO_Q, HEADER_LOCK_PREAMBLE_TWO_TAIL} : VFO_SLOT;
					ST_AM1, ST_AM2: d = {AM_HEAD, t[15:14] == 2'b00, 1'b0};
					ST_ADDR1, ST_ADDR2: begin
						r  = 1'b0;
						a  = {t, seq[k] == ST_ADDR2, s};
						id = {a, crc16(a)};
						d  = {4'h0, id[39-8*i -: 8]};
					end
					ST_PA1, ST_PA2: d = {HEAD_BITS, PA_Q, PA_TAIL};
					ST_GAP: d = (z == ZONE_CTRL) ? GAP_CTRL_SLOT : GAP_STD_SLOT;
					ST_SYNC: d = sw[47-12*i -: 12];
					ST_DATA: begin
						r = 1'b0;
						d = {4'h0, bytes[i]};
					end
					ST_FILL: begin
						r = 1'b0;
						d = {4'h0, FILL_BYTE};
					end
					default: d = BUF_SLOT;
				endcase
				exp_q.push_back({!r, pv, z != ZONE_CTRL && k < 8,
					(seq[k] == ST_HEADER_LOCK_PREAMBLE_TWO && i == 0) || seq[k] == ST_PA1 || seq[k] == ST_PA2,
					r, 4'(seq[k]), d});
				if (r)
					pv = d[1:0];
			end
		end
	endtask : build

	task automatic feed();
		int   k;
		logic acc;
		k = 0;
		din = bytes[0];
		dvalid = 1'b1;
		while (k < FIFO_LEN) begin
			@(posedge clk);
			acc = dvalid && dready;
			if (acc)
				k++;
			#1;
			if (acc && k == FD)
				check(dready, 1'b0);
			din = (k < FIFO_LEN) ? bytes[k] : 8'h00;
			dvalid = (k < FIFO_LEN) && (k < FD || $urandom % 3 != 0);
		end
	endtask : feed

	task automatic run_sector(input logic [1:0] z, input logic [4:0] b, input logic [15:0] t,
			input logic [6:0] s, input logic st);
		logic [21:0] e;
		int          n, w, m0;
		foreach (bytes[i])
			bytes[i] = 8'($urandom);
		if (s[0])
			bytes[0][7:6] = 2'b00;
		build(z, b, t, s);
		m0 = marks;
		stall = st;
		{zone, band, track, sector, start} = {z, b, t, s, 1'b1};
		@(posedge clk);
		#1 start = 1'b0;
		n = 0;
		w = 0;
		fork
			feed();
			while (exp_q.size() > 0 && w < 20000) begin
				@(posedge clk);
				w++;
				if (svalid && sready) begin
					e = exp_q.pop_front();
					check({hdr, seed, sraw, field, sdata}, e[18:0]);
					if (e[21])
						check(prev, e[20:19]);
					n++;
				end
				#1 start = (n == 40);
			end
		join
		if (w >= 20000)
			fail_count++;
		repeat (2) @(posedge clk);
		#1 check({busy, svalid}, 2'b00);
		check(marks - m0, 2);
	endtask : run_sector

	task automatic refuse_and_reset();
		{zone, sector, start, stall} = {ZONE_DATA, 7'd17, 1'b1, 1'b0};
		@(posedge clk);
		#1 start = 1'b0;
		repeat (2) @(posedge clk);
		#1 check(busy, 1'b0);
		{sector, start} = {7'd16, 1'b1};
		@(posedge clk);
		#1 start = 1'b0;
		repeat (300) @(posedge clk);
		#1 rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1 check({busy, svalid, dready}, 3'b001);
	endtask : refuse_and_reset

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{start, zone, band, track, sector} = '0;
		{din, dvalid, stall, fail_count, num_checks} = '0;
		void'($urandom(32'h5c24));
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		run_sector(ZONE_LEADIN, 5'd3, 16'hffff, 7'd0, 1'b1);
		run_sector(ZONE_DATA, 5'd5, 16'h1234, 7'd16, 1'b0);
		run_sector(ZONE_DATA, 5'd6, 16'hc234, 7'd1, 1'b1);
		run_sector(ZONE_CTRL, 5'd0, 16'h8000, 7'd9, 1'b0);
		run_sector(ZONE_LEADOUT, 5'd1, 16'($urandom), 7'($urandom % 17), 1'b1);
		refuse_and_reset();
		run_sector(ZONE_DATA, 5'd2, 16'h3fff, 7'd5, 1'b0);
		finish_test();
	end

	initial begin
		#(25.0 * 60000);
		fail_count++;
		finish_test();
	end
endmodule : tb
